// *** core/adc_rate_pkg.sv ***
// Shared constants and types for the converter readout and rate control block.
// Assumes a single oscillator clock domain plus a serial clock from the host.
package adc_rate_pkg;

	// ------------------------------------------------------------
	// Widths and limits
	// ------------------------------------------------------------
	localparam int WORD_W = 24;
	localparam int DEC_W = 11;
	localparam int FIFO_DEPTH = 16;
	localparam logic [10:0] DEC_MIN = 11'h014;
	localparam logic [10:0] DEC_MAX = 11'h7FF;
	localparam logic [10:0] DEC_RESET = 11'h040;

	// ------------------------------------------------------------
	// Divider chain
	// ------------------------------------------------------------
	localparam logic [8:0] MOD_DIV_NORMAL = 9'h080;
	localparam logic [8:0] MOD_DIV_SLOW = 9'h100;

	// ------------------------------------------------------------
	// Filter selection
	// ------------------------------------------------------------
	localparam logic [1:0] FILTER_AUTO = 2'h0;
	localparam logic [1:0] FILTER_FAST = 2'h1;
	localparam logic [1:0] FILTER_SINC2 = 2'h2;
	localparam logic [1:0] FILTER_SINC3 = 2'h3;

	// ------------------------------------------------------------
	// Serial commands and register indices
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_READ_DATA = 8'h01;
	localparam logic [3:0] OP_READ_REG = 4'h1;
	localparam logic [3:0] OP_WRITE_REG = 4'h5;
	localparam logic [3:0] IDX_MODE_DEC_HIGH = 4'h6;
	localparam logic [3:0] IDX_DEC_LOW = 4'h7;
	localparam logic [4:0] CMD_BITS = 5'h08;
	localparam logic [4:0] WORD_BITS = 5'h18;

	typedef struct packed {
		logic [3:0] op;
		logic [3:0] idx;
	} serial_cmd_t;

	typedef enum logic [1:0] {DR_WAIT, DR_GUARD, DR_LOAD, DR_FRESH} drain_state_t;
	typedef enum logic [1:0] {SP_CMD, SP_READ, SP_WRITE} serial_state_t;

endpackage

// *** core/level_sync.sv ***
// Three-stage synchroniser for a level from a foreign clock domain.
// The output moves only when the second and third stage agree.
`timescale 1ns/1ps
module level_sync #(
	parameter bit RESET_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic s1;
	logic s2;
	logic s3;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
			q <= RESET_VAL;
		end
		else
		begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q <= s3;
		end
	end
endmodule

// *** core/stream_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
module stream_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("stream_fifo depth must be a power of two");

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;

	wire full = (wr_ptr ^ rd_ptr) == {1'b1, {AW{1'b0}}};
	wire empty = wr_ptr == rd_ptr;
	wire push = in_valid && !full;
	wire pop = out_ready && !empty;

	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + {{AW{1'b0}}, push};
			rd_ptr <= rd_ptr + {{AW{1'b0}}, pop};
		end
	end
endmodule

// *** core/adc_readout_and_rate_control.sv ***
// Digital readout, filter sequencing and rate divider of a delta-sigma converter.
// Assumes CLK is the oscillator, SCLK comes from the host and stops outside frames.
`timescale 1ns/1ps
module adc_readout_and_rate_control #(
	parameter int WORD_W = adc_rate_pkg::WORD_W,
	parameter int FIFO_DEPTH = adc_rate_pkg::FIFO_DEPTH
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic DIN,
	output logic DOUT,
	output logic DOUT_OE,
	output logic CONVERSION_READY_N,
	input wire logic SPEED,
	input wire logic [2:0] GAIN_SETTING,
	input wire logic [1:0] FILTER_MODE,
	input wire logic [3:0] CHANNEL,
	input wire logic MOD_BIT,
	output logic MODULATOR_TICK,
	output logic SAMPLE_TICK,
	output logic [1:0] FILTER_ORDER,
	output logic DECIMATION_REJECTED
);
	if (WORD_W < 16)
		$error("result word too narrow for the filter sum");

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic [1:0] rst_pipe;
	wire rst_n = rst_pipe[1];

	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'b1};
	end

	// ------------------------------------------------------------
	// Divider chain
	// ------------------------------------------------------------
	logic [8:0] mod_cnt;
	logic speed_q;
	wire [8:0] mod_div = SPEED ? adc_rate_pkg::MOD_DIV_SLOW : adc_rate_pkg::MOD_DIV_NORMAL;
	wire speed_change = SPEED != speed_q;
	wire mod_tick = (mod_cnt == mod_div - 9'h001) && !speed_change;
	wire [1:0] samp_shift = (GAIN_SETTING <= 3'h3) ? 2'h0 :
		(GAIN_SETTING == 3'h4) ? 2'h1 : (GAIN_SETTING == 3'h5) ? 2'h2 : 2'h3;
	wire [8:0] samp_mask = (mod_div >> samp_shift) - 9'h001;
	wire samp_tick = ((mod_cnt & samp_mask) == samp_mask) && !speed_change;
	wire [8:0] next_mod_cnt = (mod_tick || speed_change) ? 9'h000 : mod_cnt + 9'h001;

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mod_cnt <= 9'h000;
			speed_q <= 1'b0;
			MODULATOR_TICK <= 1'b0;
			SAMPLE_TICK <= 1'b0;
		end
		else
		begin
			mod_cnt <= next_mod_cnt;
			speed_q <= SPEED;
			MODULATOR_TICK <= mod_tick;
			SAMPLE_TICK <= samp_tick;
		end
	end

	// ------------------------------------------------------------
	// Decimation ratio taken over from the serial side
	// ------------------------------------------------------------
	logic [10:0] decimation;
	logic [10:0] dec_pending;
	logic wr_tgl;
	logic wr_tgl_s;
	logic wr_tgl_q;
	wire wr_evt = wr_tgl_s ^ wr_tgl_q;
	// The upper bound holds by width; only the lower bound needs a check
	wire dec_ok = dec_pending >= adc_rate_pkg::DEC_MIN;
	wire dec_load = wr_evt && dec_ok;

	level_sync u_wr_sync (
		.clk(CLK),
		.rst_n(rst_n),
		.d(wr_tgl),
		.q(wr_tgl_s)
	);

	// dec_pending is stable for several CLK edges around its toggle
	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_tgl_q <= 1'b0;
			decimation <= adc_rate_pkg::DEC_RESET;
			DECIMATION_REJECTED <= 1'b0;
		end
		else
		begin
			wr_tgl_q <= wr_tgl_s;
			if (wr_evt && dec_ok)
				decimation <= dec_pending;
			if (wr_evt)
				DECIMATION_REJECTED <= !dec_ok;
		end
	end

	// ------------------------------------------------------------
	// Decimator and filter sequencing
	// ------------------------------------------------------------
	logic [10:0] dec_cnt;
	logic signed [13:0] period_sum;
	logic signed [13:0] hist1;
	logic signed [13:0] hist2;
	logic [1:0] settle;
	logic [3:0] chan_q;
	logic word_valid;
	logic [WORD_W-1:0] word_data;
	logic fifo_in_ready;
	wire chan_change = CHANNEL != chan_q;
	// A finished word that the FIFO cannot take freezes the decimator
	wire mod_step = mod_tick && !word_valid;
	wire signed [13:0] step = MOD_BIT ? 14'sh0001 : 14'sh3FFF;
	wire signed [13:0] sum_now = period_sum + step;
	wire period_end = mod_step && (dec_cnt == decimation - 11'h001) && !dec_load;
	wire [1:0] order = (FILTER_MODE == adc_rate_pkg::FILTER_AUTO) ?
		settle + 2'h1 : FILTER_MODE;
	wire signed [13:0] part2 = (order >= adc_rate_pkg::FILTER_SINC2) ? hist1 : 14'sh0000;
	wire signed [13:0] part3 = (order == adc_rate_pkg::FILTER_SINC3) ? hist2 : 14'sh0000;
	wire signed [13:0] word_sum = sum_now + part2 + part3;

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dec_cnt <= 11'h000;
			period_sum <= 14'sh0000;
			hist1 <= 14'sh0000;
			hist2 <= 14'sh0000;
			settle <= 2'h0;
			chan_q <= 4'h0;
			FILTER_ORDER <= adc_rate_pkg::FILTER_FAST;
		end
		else if (chan_change)
		begin
			// Old history belongs to the previous channel
			chan_q <= CHANNEL;
			dec_cnt <= 11'h000;
			period_sum <= 14'sh0000;
			hist1 <= 14'sh0000;
			hist2 <= 14'sh0000;
			settle <= 2'h0;
		end
		else if (dec_load)
		begin
			// A smaller ratio could leave the count past its end; start a fresh period
			dec_cnt <= 11'h000;
			period_sum <= 14'sh0000;
		end
		else if (period_end)
		begin
			dec_cnt <= 11'h000;
			period_sum <= 14'sh0000;
			hist1 <= sum_now;
			hist2 <= hist1;
			FILTER_ORDER <= order;
			if (settle != 2'h2)
				settle <= settle + 2'h1;
		end
		else if (mod_step)
		begin
			dec_cnt <= dec_cnt + 11'h001;
			period_sum <= sum_now;
		end
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			word_valid <= 1'b0;
			word_data <= '0;
		end
		else if (period_end && !chan_change)
		begin
			word_valid <= 1'b1;
			word_data <= {{(WORD_W-14){word_sum[13]}}, word_sum};
		end
		else if (fifo_in_ready)
			word_valid <= 1'b0;
	end

	// ------------------------------------------------------------
	// Output buffer
	// ------------------------------------------------------------
	logic fifo_out_valid;
	logic [WORD_W-1:0] fifo_out_data;
	adc_rate_pkg::drain_state_t dstate;
	adc_rate_pkg::drain_state_t next_dstate;
	wire fifo_out_ready = dstate == adc_rate_pkg::DR_LOAD;

	stream_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(rst_n),
		.in_valid(word_valid),
		.in_ready(fifo_in_ready),
		.in_data(word_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	// ------------------------------------------------------------
	// Result register and ready indication
	// ------------------------------------------------------------
	logic [WORD_W-1:0] result_reg;
	logic rd_tgl;
	logic rd_tgl_s;
	logic rd_tgl_q;
	wire rd_evt = rd_tgl_s ^ rd_tgl_q;

	level_sync u_rd_sync (
		.clk(CLK),
		.rst_n(rst_n),
		.d(rd_tgl),
		.q(rd_tgl_s)
	);

	always_comb
	begin
		next_dstate = dstate;
		unique case (dstate)
			adc_rate_pkg::DR_WAIT:
				if (fifo_out_valid)
					next_dstate = adc_rate_pkg::DR_GUARD;
			adc_rate_pkg::DR_GUARD:
				next_dstate = adc_rate_pkg::DR_LOAD;
			adc_rate_pkg::DR_LOAD:
				next_dstate = adc_rate_pkg::DR_FRESH;
			adc_rate_pkg::DR_FRESH:
				if (rd_evt)
					next_dstate = adc_rate_pkg::DR_WAIT;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dstate <= adc_rate_pkg::DR_WAIT;
			CONVERSION_READY_N <= 1'b1;
			result_reg <= '0;
			rd_tgl_q <= 1'b0;
		end
		else
		begin
			dstate <= next_dstate;
			rd_tgl_q <= rd_tgl_s;
			CONVERSION_READY_N <= next_dstate != adc_rate_pkg::DR_FRESH;
			if (fifo_out_ready)
				result_reg <= fifo_out_data;
		end
	end

	// ------------------------------------------------------------
	// Serial port, SCLK domain
	// ------------------------------------------------------------
	// Deselect clears the frame; with select tied low framing runs by bit count
	wire sp_rst_n = rst_n && !CS_N;
	adc_rate_pkg::serial_state_t sstate;
	logic [4:0] bit_cnt;
	logic [4:0] out_len;
	logic [7:0] in_shift;
	logic [WORD_W-1:0] out_shift;
	logic [3:0] wr_idx;
	logic ready_s;
	wire [7:0] in_byte = {in_shift[6:0], DIN};
	adc_rate_pkg::serial_cmd_t cmd;
	assign cmd = in_byte;
	wire [4:0] bit_limit = (sstate == adc_rate_pkg::SP_READ) ? out_len : adc_rate_pkg::CMD_BITS;
	wire last_bit = bit_cnt == bit_limit - 5'h01;
	wire in_cmd = (sstate == adc_rate_pkg::SP_CMD) && last_bit;
	wire is_rdata = in_byte == adc_rate_pkg::CMD_READ_DATA;
	wire is_rreg = cmd.op == adc_rate_pkg::OP_READ_REG;
	wire idx_known = (cmd.idx == adc_rate_pkg::IDX_MODE_DEC_HIGH) ||
		(cmd.idx == adc_rate_pkg::IDX_DEC_LOW);
	wire is_wreg = (cmd.op == adc_rate_pkg::OP_WRITE_REG) && idx_known;
	wire [7:0] mode_val = {ready_s, 4'h0, dec_pending[10:8]};
	wire [7:0] reg_val = (cmd.idx == adc_rate_pkg::IDX_MODE_DEC_HIGH) ? mode_val :
		(cmd.idx == adc_rate_pkg::IDX_DEC_LOW) ? dec_pending[7:0] : 8'h00;
	wire rd_finish = (sstate == adc_rate_pkg::SP_READ) && last_bit &&
		(out_len == adc_rate_pkg::WORD_BITS);
	wire wr_finish = (sstate == adc_rate_pkg::SP_WRITE) && last_bit;

	level_sync #(
		.RESET_VAL(1'b1)
	) u_ready_sync (
		.clk(SCLK),
		.rst_n(rst_n),
		.d(CONVERSION_READY_N),
		.q(ready_s)
	);

	always_ff @(posedge SCLK or negedge sp_rst_n)
	begin
		if (!sp_rst_n)
		begin
			sstate <= adc_rate_pkg::SP_CMD;
			bit_cnt <= 5'h00;
			out_len <= 5'h00;
			in_shift <= 8'h00;
			out_shift <= '0;
			wr_idx <= 4'h0;
		end
		else
		begin
			in_shift <= in_byte;
			bit_cnt <= last_bit ? 5'h00 : bit_cnt + 5'h01;
			unique case (sstate)
				adc_rate_pkg::SP_CMD:
					if (last_bit && is_rdata)
					begin
						// Word is quiet while ready is low, so no resync is needed
						out_shift <= result_reg;
						out_len <= adc_rate_pkg::WORD_BITS;
						sstate <= adc_rate_pkg::SP_READ;
					end
					else if (last_bit && is_rreg)
					begin
						out_shift <= {reg_val, {(WORD_W-8){1'b0}}};
						out_len <= adc_rate_pkg::CMD_BITS;
						sstate <= adc_rate_pkg::SP_READ;
					end
					else if (last_bit && is_wreg)
					begin
						wr_idx <= cmd.idx;
						sstate <= adc_rate_pkg::SP_WRITE;
					end
				adc_rate_pkg::SP_READ:
				begin
					out_shift <= {out_shift[WORD_W-2:0], 1'b0};
					if (last_bit)
						sstate <= adc_rate_pkg::SP_CMD;
				end
				adc_rate_pkg::SP_WRITE:
					if (last_bit)
						sstate <= adc_rate_pkg::SP_CMD;
				default:
					sstate <= adc_rate_pkg::SP_CMD;
			endcase
		end
	end

	// Toggles and the written ratio survive deselect
	always_ff @(posedge SCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_tgl <= 1'b0;
			wr_tgl <= 1'b0;
			dec_pending <= adc_rate_pkg::DEC_RESET;
		end
		else if (!CS_N)
		begin
			if (rd_finish)
				rd_tgl <= !rd_tgl;
			if (wr_finish)
				wr_tgl <= !wr_tgl;
			if (wr_finish && wr_idx == adc_rate_pkg::IDX_MODE_DEC_HIGH)
				dec_pending[10:8] <= in_byte[2:0];
			if (wr_finish && wr_idx == adc_rate_pkg::IDX_DEC_LOW)
				dec_pending[7:0] <= in_byte;
		end
	end

	// Output changes on the falling edge so the host samples it on the rising one
	always_ff @(negedge SCLK or negedge sp_rst_n)
	begin
		if (!sp_rst_n)
			DOUT <= 1'b0;
		else
			DOUT <= out_shift[WORD_W-1];
	end

	assign DOUT_OE = !CS_N && rst_n;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	ready_fall_a: assert property (@(posedge CLK) disable iff (!rst_n)
		dstate == adc_rate_pkg::DR_LOAD |=> !CONVERSION_READY_N && result_reg == $past(fifo_out_data))
		else $error("ready did not fall with the new word");
	ready_rise_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(dstate == adc_rate_pkg::DR_FRESH && rd_evt) |=> CONVERSION_READY_N [*2])
		else $error("ready did not rise after the read");
	guard_update_a: assert property (@(posedge CLK) disable iff (!rst_n)
		!$stable(result_reg) |-> $past(CONVERSION_READY_N, 1) && $past(CONVERSION_READY_N, 2))
		else $error("result changed while ready was low");
	mode_mirror_a: assert property (@(posedge SCLK) disable iff (!sp_rst_n)
		(in_cmd && is_rreg && cmd.idx == adc_rate_pkg::IDX_MODE_DEC_HIGH)
		|=> out_shift[WORD_W-1] == $past(ready_s))
		else $error("mode register bit 7 does not mirror ready");
	filter_order_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(period_end && !chan_change) |=> word_valid && FILTER_ORDER == $past(order))
		else $error("word built without a filter order");
	auto_fast_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(chan_change && FILTER_MODE == adc_rate_pkg::FILTER_AUTO) |=> order == adc_rate_pkg::FILTER_FAST)
		else $error("auto mode did not restart with fast filter");
	dec_range_a: assert property (@(posedge CLK) disable iff (!rst_n)
		decimation >= adc_rate_pkg::DEC_MIN && dec_cnt < decimation)
		else $error("decimation out of range");
	mod_rate_a: assert property (@(posedge CLK) disable iff (!rst_n)
		(mod_tick && !SPEED) |=> (!mod_tick || speed_change) [*8])
		else $error("modulator tick spacing wrong");
	sample_align_a: assert property (@(posedge CLK) disable iff (!rst_n)
		mod_tick |-> samp_tick ##1 SAMPLE_TICK && MODULATOR_TICK)
		else $error("sample tick not aligned to modulator tick");
	bus_idle_a: assert property (@(posedge CLK) disable iff (!rst_n)
		CS_N |-> !DOUT_OE && !DOUT)
		else $error("bus driven while deselected");
endmodule

// *** tb/host_serial_model.sv ***
// Host microcontroller model acting as serial master of the converter.
// Assumes the bench calls frame only while CLK-side reset has been released.
`timescale 1ns/1ps
module host_serial_model (
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	// ------------------------------------------------------------
	// Idle state
	// ------------------------------------------------------------
	// Serial clock stands low outside frames
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		din = 1'b0;
	end

	// ------------------------------------------------------------
	// Frame engine
	// ------------------------------------------------------------
	// Mode 0 selects for this frame only, 1 leaves select low, 2 never selects
	task automatic frame(input logic [31:0] tx, input int n, input int mode,
		output logic [31:0] rx);
		int i;
		rx = 32'h00000000;
		if (mode != 2)
			cs_n = 1'b0;
		#16;
		for (i = n - 1; i >= 0; i--)
		begin
			din = tx[i];
			#8;
			sclk = 1'b1;
			// An undriven line reads as the inverse of the last bit, never as a stale value
			rx = {rx[30:0], dout_oe ? dout : ~rx[0]};
			#16;
			sclk = 1'b0;
			#8;
		end
		#8;
		if (mode == 0)
			cs_n = 1'b1;
		din = ~din;
		// Keeps a deselect visible between two back-to-back frames
		#16;
	endtask
endmodule

// *** tb/adc_readout_and_rate_control_bench.sv ***
// Self-checking bench for the converter readout and rate control block.
// Assumes the host model in host_serial_model.sv and the design package.
`timescale 1ns/1ps
module adc_readout_and_rate_control_bench;
	// ------------------------------------------------------------
	// Signals and table
	// ------------------------------------------------------------
	// A shallower queue keeps the fill test short
	localparam int FD = 8;
	typedef struct {
		logic speed;
		logic [2:0] gain;
		logic [1:0] fmode;
		logic mbit;
		int modp;
		int sampp;
		logic [23:0] word;
		logic [1:0] ord;
		bit chk;
	} row_t;
	row_t rows [8] = '{
		'{1'b0, 3'h0, adc_rate_pkg::FILTER_FAST, 1'b1, 128, 128, 24'h000014, 2'h1, 1'b1},
		'{1'b0, 3'h4, adc_rate_pkg::FILTER_SINC2, 1'b0, 128, 64, 24'hFFFFD8, 2'h2, 1'b1},
		'{1'b0, 3'h5, adc_rate_pkg::FILTER_SINC3, 1'b1, 128, 32, 24'h00003C, 2'h3, 1'b1},
		'{1'b1, 3'h1, adc_rate_pkg::FILTER_SINC3, 1'b1, 256, 256, 24'h000000, 2'h3, 1'b0},
		'{1'b1, 3'h7, adc_rate_pkg::FILTER_SINC3, 1'b1, 256, 32, 24'h000000, 2'h3, 1'b0},
		'{1'b0, 3'h6, adc_rate_pkg::FILTER_SINC3, 1'b1, 128, 16, 24'h000000, 2'h3, 1'b0},
		'{1'b0, 3'h3, adc_rate_pkg::FILTER_SINC3, 1'b1, 128, 128, 24'h000000, 2'h3, 1'b0},
		'{1'b0, 3'h2, adc_rate_pkg::FILTER_SINC3, 1'b1, 128, 128, 24'h000000, 2'h3, 1'b0}
	};
	logic clk;
	logic rstn;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout;
	logic dout_oe;
	logic ready_n;
	logic speed;
	logic [2:0] gain;
	logic [1:0] fmode;
	logic [3:0] channel;
	logic mod_bit;
	logic mod_tick;
	logic sample_tick;
	logic [1:0] filter_order;
	logic rejected;
	int bad_count = 0;
	int samples_checked = 0;
	time fall_t = 0;
	time prev_t = 0;

	adc_readout_and_rate_control #(.FIFO_DEPTH(FD)) adc_readout_and_rate_control_inst (
		.CLK(clk), .RSTN(rstn), .SCLK(sclk), .CS_N(cs_n), .DIN(din), .DOUT(dout),
		.DOUT_OE(dout_oe), .CONVERSION_READY_N(ready_n), .SPEED(speed),
		.GAIN_SETTING(gain), .FILTER_MODE(fmode), .CHANNEL(channel), .MOD_BIT(mod_bit),
		.MODULATOR_TICK(mod_tick), .SAMPLE_TICK(sample_tick),
		.FILTER_ORDER(filter_order), .DECIMATION_REJECTED(rejected)
	);
	host_serial_model host_serial_model_inst (
		.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic results;
		$display("compared %0d, mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic fail;
		bad_count++;
		$display("[ERR] %0t ns: wait ran out", $time);
		results();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [3:0] idx, input logic [7:0] val);
		logic [31:0] rx;
		host_serial_model_inst.frame({16'h0000, adc_rate_pkg::OP_WRITE_REG, idx, val}, 16, 0, rx);
		cyc(12);
	endtask
	task automatic rreg(input logic [3:0] idx, input int mode, output logic [7:0] val);
		logic [31:0] rx;
		host_serial_model_inst.frame({16'h0000, adc_rate_pkg::OP_READ_REG, idx, 8'h00}, 16, mode,
			rx);
		val = rx[7:0];
	endtask
	// Ticks right after a setting change are skipped; the last full gap is returned
	task automatic measure(input bit smp, output int p);
		int i;
		int k;
		p = 0;
		for (k = 0; k < 3; k++)
		begin
			for (i = 1; i <= 600; i++)
			begin
				cyc(1);
				if ((smp ? sample_tick : mod_tick) === 1'b1)
					break;
			end
			if (i > 600)
				fail();
			p = i;
		end
	endtask
	task automatic get_word(input int bound, input bit need, input int mode, output bit ok,
		output logic [23:0] w, output logic [1:0] ord);
		int i;
		logic [31:0] rx;
		w = 24'h000000;
		for (i = 0; i < bound && ready_n !== 1'b0; i++)
			cyc(1);
		ok = (ready_n === 1'b0);
		ord = filter_order;
		if (!ok)
		begin
			if (need)
				fail();
			return;
		end
		prev_t = fall_t;
		fall_t = $time;
		host_serial_model_inst.frame({adc_rate_pkg::CMD_READ_DATA, 24'h000000}, 32, mode, rx);
		w = rx[23:0];
		cyc(1);
		for (i = 0; i < 12 && ready_n !== 1'b1; i++)
			cyc(1);
		check(ready_n, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		int r;
		int k;
		int p;
		int n;
		bit ok;
		logic [23:0] w;
		logic [1:0] o;
		logic [7:0] v;
		logic [31:0] rx;
		rstn = 1'b0;
		speed = 1'b0;
		gain = 3'h0;
		fmode = adc_rate_pkg::FILTER_FAST;
		channel = 4'h0;
		mod_bit = 1'b1;
		cyc(3);
		check(ready_n, 1'b1);
		check(dout_oe, 1'b0);
		check(rejected, 1'b0);
		rstn = 1'b1;
		cyc(4);
		wreg(adc_rate_pkg::IDX_DEC_LOW, 8'hFF);
		wreg(adc_rate_pkg::IDX_MODE_DEC_HIGH, 8'h07);
		check(rejected, 1'b0);
		rreg(adc_rate_pkg::IDX_MODE_DEC_HIGH, 0, v);
		check(v, 8'h87);
		wreg(adc_rate_pkg::IDX_MODE_DEC_HIGH, 8'h00);
		wreg(adc_rate_pkg::IDX_DEC_LOW, 8'h13);
		check(rejected, 1'b1);
		// A refused byte stays readable; only the ratio in use keeps its last good value
		rreg(adc_rate_pkg::IDX_DEC_LOW, 0, v);
		check(v, 8'h13);
		wreg(adc_rate_pkg::IDX_DEC_LOW, 8'h14);
		check(rejected, 1'b0);
		// An unselected device must ignore a full write frame
		host_serial_model_inst.frame({16'h0000, adc_rate_pkg::OP_WRITE_REG,
			adc_rate_pkg::IDX_DEC_LOW, 8'h13}, 16, 2, rx);
		cyc(12);
		check(rejected, 1'b0);
		rreg(adc_rate_pkg::IDX_DEC_LOW, 0, v);
		check(v, 8'h14);
		for (r = 0; r < 8; r++)
		begin
			speed = rows[r].speed;
			gain = rows[r].gain;
			fmode = rows[r].fmode;
			mod_bit = rows[r].mbit;
			measure(1'b0, p);
			check(p, rows[r].modp);
			measure(1'b1, p);
			check(p, rows[r].sampp);
			if (rows[r].chk)
			begin
				// Four words flush any history from the previous setting
				for (k = 0; k < 4; k++)
					get_word(6000, 1'b1, 0, ok, w, o);
				check(w, rows[r].word);
				check(o, rows[r].ord);
				check(32'((fall_t - prev_t) / 100), 20 * rows[r].modp);
			end
		end
		get_word(6000, 1'b1, 0, ok, w, o);
		// Switch first so that a word still in flight from the old setting is drained too
		fmode = adc_rate_pkg::FILTER_AUTO;
		channel = 4'h5;
		for (k = 0; ok && k < 20; k++)
			get_word(30, 1'b0, 0, ok, w, o);
		check(ok, 1'b0);
		for (k = 1; k <= 4; k++)
		begin
			get_word(6000, 1'b1, 0, ok, w, o);
			check(o, (k < 3) ? k : 3);
		end
		check(w, 24'h00003C);
		// Three-wire exchange with the select line held low throughout
		for (k = 0; k < 6000 && ready_n !== 1'b0; k++)
			cyc(1);
		if (ready_n !== 1'b0)
			fail();
		rreg(adc_rate_pkg::IDX_MODE_DEC_HIGH, 1, v);
		check(v, 8'h00);
		get_word(20, 1'b1, 1, ok, w, o);
		check(w, 24'h00003C);
		rreg(adc_rate_pkg::IDX_MODE_DEC_HIGH, 0, v);
		check(v, 8'h80);
		cyc(200);
		check(ready_n, 1'b1);
		// Leave the queue unread past full: result, queue and one held word remain
		cyc((FD + 3) * 2560);
		n = 0;
		ok = 1'b1;
		for (k = 0; ok && k < 20; k++)
		begin
			get_word(30, 1'b0, 0, ok, w, o);
			if (ok)
			begin
				n++;
				check(w, 24'h00003C);
			end
		end
		check(n, FD + 2);
		results();
	end
endmodule
